// ==== src/csf_core.sv ====
// Purpose: Accumulator, program counter low byte, table pointers and status flags.
// Assumes: One clock, Wishbone classic slave, commands issued by register writes.
// Notes: Commands arrive as register writes; each bus request gets one answer.
// Contract
// [RQ1] Every ALU result is stored in the working accumulator.
// [RQ2] Moves between user registers go through the accumulator only.
// [RQ3] Writing the pc low byte jumps within the current page, leaving the high bits.
// [RQ4] A pc low byte write inserts one dummy cycle before execution continues.
// [RQ5] Software loads the table pointers before a table read and may step them after.
// [RQ6] A table read puts the high byte of the fetched word into the table high register.
// [RQ7] The 8-bit status has bits 7 and 6 zero and the six flags in bits 5 down to 0.
// [RQ8] Status writes never change the time-out or power-down flags.
// [RQ9] Carry is set on add carry or subtract no-borrow, and rotates through carry update it.
// [RQ10] Half carry is set on low-nibble carry or no nibble borrow on subtract.
// [RQ11] Zero is set when an arithmetic or logical result is zero.
// [RQ12] Overflow is set when carry into the top bit differs from carry out of it.
// [RQ13] Power-down is cleared by power-up or watchdog clear and set only by halt.
// [RQ14] Time-out is cleared by power-up, watchdog clear or halt and set by a time-out.
// [RQ15] The status register is never saved automatically on interrupt or call.
// [RQ16] After reset time-out and power-down read zero; arithmetic flags are undefined.
`timescale 1ns/10ps
`default_nettype none
module csf_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic exec_stall,
   output logic irq
);
   import csf_pkg::*;

   logic [7:0] work_accumulator_ff;
   logic [7:0] pc_low_byte_ff;
   logic [7:0] pc_high_ff;
   logic [7:0] table_ptr_low_ff;
   logic [7:0] table_ptr_high_ff;
   logic [7:0] table_read_high_byte_ff;
   logic [7:0] table_low_ff;
   logic [7:0] operand_ff;
   logic [7:0] result_ff;
   logic [15:0] tdata_ff;
   csf_aflags_t aflags_ff;
   logic watchdog_expired_flag_ff;
   logic power_down_flag_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   csf_state_t state_ff;
   logic wr;
   logic rd;
   logic cmd_go;
   csf_op_t op;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_hc;
   logic alu_vf;
   logic arith;
   logic logic_op;
   logic [3:0] irq_set;
   logic [7:0] status_rd;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   assign cmd_go = wr && (wb_adr_i == ADR_CMD) && (state_ff == ST_RUN);
   assign op = csf_op_t'(wb_dat_i[3:0]);
   assign status_rd = {2'b00, watchdog_expired_flag_ff, power_down_flag_ff, aflags_ff}; // [RQ7]

   // ----------------------------------------
   // ALU
   // ----------------------------------------
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      alu_res = 8'h00;
      alu_c = aflags_ff.c;
      alu_hc = aflags_ff.half_carry_flag;
      alu_vf = aflags_ff.signed_overflow_flag;
      arith = 1'b0;
      logic_op = 1'b0;
      case (op)
         OP_ADD: begin
            sum = {1'b0, work_accumulator_ff} + {1'b0, operand_ff};
            nib = {1'b0, work_accumulator_ff[3:0]} + {1'b0, operand_ff[3:0]};
            arith = 1'b1;
         end
         OP_SUB: begin
            sum = {1'b0, work_accumulator_ff} + {1'b0, ~operand_ff} + 9'h001;
            nib = {1'b0, work_accumulator_ff[3:0]} + {1'b0, ~operand_ff[3:0]} + 5'h01;
            arith = 1'b1;
         end
         OP_AND: begin
            alu_res = work_accumulator_ff & operand_ff;
            logic_op = 1'b1;
         end
         OP_OR: begin
            alu_res = work_accumulator_ff | operand_ff;
            logic_op = 1'b1;
         end
         OP_XOR: begin
            alu_res = work_accumulator_ff ^ operand_ff;
            logic_op = 1'b1;
         end
         OP_RLC: begin
            alu_res = {work_accumulator_ff[6:0], aflags_ff.c};
            alu_c = work_accumulator_ff[7]; // [RQ9]
         end
         OP_RRC: begin
            alu_res = {aflags_ff.c, work_accumulator_ff[7:1]};
            alu_c = work_accumulator_ff[0]; // [RQ9]
         end
         default: begin
            alu_res = 8'h00;
         end
      endcase
      if (arith) begin
         alu_res = sum[7:0];
         alu_c = sum[8]; // [RQ9]
         alu_hc = nib[4]; // [RQ10]
         alu_vf = sum[8] ^ (work_accumulator_ff[7] ^ operand_ff[7] ^ op[1] ^ sum[7]); // [RQ12]
      end
   end

   // ----------------------------------------
   // Accumulator and moves
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         work_accumulator_ff <= 8'h00;
         result_ff <= 8'h00;
      end else if (wr && wb_adr_i == ADR_ACCUM) begin
         work_accumulator_ff <= wb_dat_i[7:0];
      end else if (cmd_go) begin
         if (arith || logic_op || op == OP_RLC || op == OP_RRC) begin
            work_accumulator_ff <= alu_res; // [RQ1]
         end else if (op == OP_MOVA) begin
            work_accumulator_ff <= operand_ff; // [RQ2]
         end else if (op == OP_MOVR) begin
            result_ff <= work_accumulator_ff; // [RQ2]
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         operand_ff <= 8'h00;
         tdata_ff <= 16'h0000;
      end else if (wr && wb_adr_i == ADR_OPND) begin
         operand_ff <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i == ADR_TDAT) begin
         tdata_ff <= wb_dat_i[15:0];
      end
   end

   // ----------------------------------------
   // Program counter and dummy cycle
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_low_byte_ff <= 8'h00;
         pc_high_ff <= PCH_RST;
      end else if (wr && wb_adr_i == ADR_PC_LO && state_ff == ST_RUN) begin
         pc_low_byte_ff <= wb_dat_i[7:0]; // [RQ3]
      end else if (wr && wb_adr_i == ADR_PCH) begin
         pc_high_ff <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_RUN;
         exec_stall <= 1'b0;
      end else if (wr && wb_adr_i == ADR_PC_LO && state_ff == ST_RUN) begin
         state_ff <= ST_DUMMY; // [RQ4]
         exec_stall <= 1'b1;
      end else begin
         state_ff <= ST_RUN;
         exec_stall <= 1'b0;
      end
   end

   // ----------------------------------------
   // Table read
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         table_ptr_low_ff <= 8'h00;
         table_ptr_high_ff <= 8'h00;
         table_read_high_byte_ff <= 8'h00;
         table_low_ff <= 8'h00;
      end else if (wr && wb_adr_i == ADR_PTR_LO) begin
         table_ptr_low_ff <= wb_dat_i[7:0]; // [RQ5]
      end else if (wr && wb_adr_i == ADR_PTR_HI) begin
         table_ptr_high_ff <= wb_dat_i[7:0]; // [RQ5]
      end else if (cmd_go && op == OP_TABRD) begin
         table_read_high_byte_ff <= tdata_ff[15:8]; // [RQ6]
         table_low_ff <= tdata_ff[7:0];
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aflags_ff <= '0; // [RQ16]
      end else if (wr && wb_adr_i == ADR_STAT) begin
         aflags_ff <= csf_aflags_t'(wb_dat_i[3:0] & STAT_WMASK[3:0]); // [RQ8]
      end else if (cmd_go && (arith || logic_op || op == OP_RLC || op == OP_RRC)) begin
         aflags_ff.c <= alu_c;
         aflags_ff.half_carry_flag <= alu_hc;
         aflags_ff.signed_overflow_flag <= alu_vf;
         if (arith || logic_op) begin
            aflags_ff.z <= (alu_res == 8'h00); // [RQ11]
         end
      end
   end

   // The system flags ignore status writes; no save happens on call or interrupt. [RQ15]
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         power_down_flag_ff <= 1'b0; // [RQ16]
         watchdog_expired_flag_ff <= 1'b0;
      end else if (cmd_go) begin
         if (op == OP_WD_CLEAR) begin
            power_down_flag_ff <= 1'b0; // [RQ13]
            watchdog_expired_flag_ff <= 1'b0; // [RQ14]
         end else if (op == OP_HALT) begin
            power_down_flag_ff <= 1'b1; // [RQ13]
            watchdog_expired_flag_ff <= 1'b0; // [RQ14]
         end else if (op == OP_WD_EXPIRE) begin
            watchdog_expired_flag_ff <= 1'b1; // [RQ14]
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign irq_set = {cmd_go && arith && sum[7:0] == 8'h00,
                     cmd_go && op == OP_WD_EXPIRE,
                     cmd_go && op == OP_TABRD,
                     state_ff == ST_DUMMY};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_ff <= IRQ_RST;
      end else if (wr && wb_adr_i == ADR_IRQ) begin
         irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[3:0]) | irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_mask_ff <= IRQ_RST;
         irq <= 1'b0;
      end else begin
         if (wr && wb_adr_i == ADR_MASK) begin
            irq_mask_ff <= wb_dat_i[3:0];
         end
         irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h00000000;
         if (rd) begin
            if (wb_adr_i == ADR_ACCUM) begin
               wb_dat_o <= {24'h000000, work_accumulator_ff};
            end else if (wb_adr_i == ADR_PC_LO) begin
               wb_dat_o <= {24'h000000, pc_low_byte_ff};
            end else if (wb_adr_i == ADR_PCH) begin
               wb_dat_o <= {24'h000000, pc_high_ff};
            end else if (wb_adr_i == ADR_PTR_LO) begin
               wb_dat_o <= {24'h000000, table_ptr_low_ff};
            end else if (wb_adr_i == ADR_PTR_HI) begin
               wb_dat_o <= {24'h000000, table_ptr_high_ff};
            end else if (wb_adr_i == ADR_TBL_HI) begin
               wb_dat_o <= {24'h000000, table_read_high_byte_ff};
            end else if (wb_adr_i == ADR_STAT) begin
               wb_dat_o <= {24'h000000, status_rd};
            end else if (wb_adr_i == ADR_OPND) begin
               wb_dat_o <= {24'h000000, operand_ff};
            end else if (wb_adr_i == ADR_RES) begin
               wb_dat_o <= {24'h000000, result_ff};
            end else if (wb_adr_i == ADR_TDAT) begin
               wb_dat_o <= {16'h0000, tdata_ff};
            end else if (wb_adr_i == ADR_IRQ) begin
               wb_dat_o <= {28'h0000000, irq_stat_ff};
            end else if (wb_adr_i == ADR_MASK) begin
               wb_dat_o <= {28'h0000000, irq_mask_ff};
            end else if (wb_adr_i == ADR_TLOW) begin
               wb_dat_o <= {24'h000000, table_low_ff};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== src/csf_pkg.sv ====
// Purpose: Shared constants and types for the core status and accumulator datapath.
// Assumes: Registers are reached over classic Wishbone with 32-bit data.
// Notes: Register data sits in the low bits of each word.
`default_nettype none
package csf_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADR_ACCUM = 8'h00;
   localparam logic [7:0] ADR_PC_LO = 8'h04;
   localparam logic [7:0] ADR_PCH = 8'h08;
   localparam logic [7:0] ADR_PTR_LO = 8'h0c;
   localparam logic [7:0] ADR_PTR_HI = 8'h10;
   localparam logic [7:0] ADR_TBL_HI = 8'h14;
   localparam logic [7:0] ADR_STAT = 8'h18;
   localparam logic [7:0] ADR_CMD = 8'h1c;
   localparam logic [7:0] ADR_OPND = 8'h20;
   localparam logic [7:0] ADR_RES = 8'h24;
   localparam logic [7:0] ADR_TDAT = 8'h28;
   localparam logic [7:0] ADR_IRQ = 8'h2c;
   localparam logic [7:0] ADR_MASK = 8'h30;
   localparam logic [7:0] ADR_TLOW = 8'h34;
   // ----------------------------------------
   // Status field positions
   // ----------------------------------------
   localparam int B_C = 0;
   localparam int B_HC = 1;
   localparam int B_Z = 2;
   localparam int B_VF = 3;
   localparam int B_PWD = 4;
   localparam int B_TO = 5;
   localparam logic [7:0] STAT_WMASK = 8'h0f;
   // ----------------------------------------
   // Interrupt status bits
   // ----------------------------------------
   localparam int I_JMP = 0;
   localparam int I_TBL = 1;
   localparam int I_TO = 2;
   localparam int I_ZERO = 3;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam logic [7:0] PCH_RST = 8'h00;
   // ----------------------------------------
   // Commands
   // ----------------------------------------
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
      OP_OR = 4'h4, OP_XOR = 4'h5, OP_RLC = 4'h6, OP_RRC = 4'h7,
      OP_MOVA = 4'h8, OP_MOVR = 4'h9, OP_TABRD = 4'ha, OP_HALT = 4'hb,
      OP_WD_CLEAR = 4'hc, OP_WD_EXPIRE = 4'hd
   } csf_op_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00, ST_DUMMY = 2'b01
   } csf_state_t;
   typedef struct packed {
      logic signed_overflow_flag;
      logic z;
      logic half_carry_flag;
      logic c;
   } csf_aflags_t;
endpackage
`default_nettype wire

// ==== test/csf_checker.sv ====
// Purpose: Port assertions for csf_core.
// Assumes: One clock, reset active high, bus held until ack.
// Notes: Attached to every csf_core by bind.
`timescale 1ns/10ps
`default_nettype none
module csf_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic exec_stall,
   input wire logic irq
);
   import csf_pkg::*;
   // ------
   // Checks
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   jump_dummy_a: assert property (
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == ADR_PC_LO
      && !exec_stall |=> exec_stall ##1 !exec_stall)
      else $error("dummy cycle wrong");
   stall_cause_a: assert property (
      $rose(exec_stall) |-> $past(wb_we_i && wb_adr_i == ADR_PC_LO))
      else $error("stall without jump");
   stat_width_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ADR_STAT |-> wb_dat_o[31:6] == '0)
      else $error("status upper bits set");
   tbl_byte_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ADR_TBL_HI |-> wb_dat_o[31:8] == '0)
      else $error("table byte too wide");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("data without ack");
   unmapped_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h38 |-> wb_dat_o == '0)
      else $error("unmapped read nonzero");
   reset_quiet_a: assert property ($fell(sys_rst) |-> !irq && !exec_stall && !wb_ack_o)
      else $error("outputs busy after reset");
   cover property (exec_stall);
   cover property (irq);
   cover property (wb_ack_o && !wb_we_i && wb_adr_i == ADR_TBL_HI);
endmodule
bind csf_core csf_checker chk_i (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .exec_stall(exec_stall), .irq(irq));
`default_nettype wire

// ==== test/csf_tb.sv ====
// Purpose: Self-checking bench for csf_core.
// Assumes: Wishbone classic, ack one cycle after request.
// Notes: Expected arithmetic flags come from a local adder model.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import csf_pkg::*;
   logic clk, sys_rst, cyc, stb, we, ack, stall, irq, sq;
   logic [3:0] sel;
   logic [7:0] adr;
   logic [31:0] di, dout, q;
   int fails, num_checks;
   csf_core dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack),
      .exec_stall(stall), .irq(irq));
   // ------
   // Helpers
   // ------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop;
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      di <= d;
      sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dout;
      sq = stall;
      if (n >= 20) begin
         fails++;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'hf);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(nm, q, e);
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask
   function automatic logic [11:0] alu(input logic sb, input logic [7:0] a, input logic [7:0] b);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] l;
      bb = sb ? ~b : b;
      s = a + bb + sb;
      h = a[3:0] + bb[3:0] + sb;
      l = a[6:0] + bb[6:0] + sb;
      return {l[7] ^ s[8], s[7:0] == 8'h0, h[4], s[8], s[7:0]};
   endfunction
   // ------
   // Scenarios
   // ------
   task automatic t_flags;
      csf_op_t cm [5] = '{OP_HALT, OP_WD_EXPIRE, OP_HALT, OP_WD_EXPIRE, OP_WD_CLEAR};
      logic [1:0] ex [5] = '{2'b01, 2'b11, 2'b01, 2'b11, 2'b00};
      bus(1'b0, ADR_STAT, 32'h0, 4'hf);
      chk("status after reset", q & 32'hf0, 32'h0);
      wr(ADR_STAT, 8'hff);
      rd(ADR_STAT, 32'h0f, "status write");
      for (int i = 0; i < 5; i++) begin
         wr(ADR_CMD, {4'h0, cm[i]});
         wr(ADR_STAT, i[0] ? 8'h00 : 8'h30);
         rd(ADR_STAT, {26'h0, ex[i], 4'h0}, "system flags");
      end
   endtask
   task automatic t_arith;
      logic [7:0] av [5] = '{8'h7f, 8'hff, 8'h80, 8'h05, 8'h03};
      logic [7:0] bv [5] = '{8'h01, 8'h01, 8'h80, 8'h03, 8'h05};
      logic [11:0] e;
      for (int i = 0; i < 10; i++) begin
         e = alu(i[0], av[i/2], bv[i/2]);
         wr(ADR_ACCUM, av[i/2]);
         wr(ADR_OPND, bv[i/2]);
         wr(ADR_CMD, {4'h0, i[0] ? OP_SUB : OP_ADD});
         rd(ADR_ACCUM, {24'h0, e[7:0]}, "sum");
         rd(ADR_STAT, {28'h0, e[11:8]}, "flags");
      end
      rd(ADR_IRQ, 32'h0c, "timeout and zero events");
   endtask
   task automatic t_logic;
      csf_op_t ops [3] = '{OP_XOR, OP_OR, OP_AND};
      logic [7:0] ov [3] = '{8'h3c, 8'h01, 8'h00};
      logic [7:0] rs [3] = '{8'h00, 8'h01, 8'h00};
      wr(ADR_STAT, 8'h0b);
      wr(ADR_ACCUM, 8'h3c);
      for (int i = 0; i < 3; i++) begin
         wr(ADR_OPND, ov[i]);
         wr(ADR_CMD, {4'h0, ops[i]});
         rd(ADR_ACCUM, {24'h0, rs[i]}, "logic result");
         rd(ADR_STAT, {28'h0, 1'b1, rs[i] == 8'h0, 2'b11}, "logic flags");
      end
      wr(ADR_STAT, 8'h00);
      wr(ADR_ACCUM, 8'h81);
      wr(ADR_CMD, {4'h0, OP_RLC});
      rd(ADR_ACCUM, 32'h02, "rotate left");
      rd(ADR_STAT, 32'h01, "rotate left carry");
      wr(ADR_CMD, {4'h0, OP_RRC});
      rd(ADR_ACCUM, 32'h81, "rotate right");
      rd(ADR_STAT, 32'h00, "rotate right carry");
   endtask
   task automatic t_move;
      wr(ADR_ACCUM, 8'h00);
      wr(ADR_OPND, 8'h5a);
      wr(ADR_CMD, {4'h0, OP_MOVA});
      rd(ADR_ACCUM, 32'h5a, "move in");
      wr(ADR_CMD, {4'h0, OP_MOVR});
      rd(ADR_RES, 32'h5a, "move out");
   endtask
   task automatic t_jump;
      wr(ADR_IRQ, 8'h0f);
      wr(ADR_MASK, 8'h01);
      wr(ADR_PCH, 8'h05);
      chk("no stall on plain write", {31'h0, sq}, 32'h0);
      wr(ADR_PC_LO, 8'h3c);
      chk("dummy cycle", {31'h0, sq}, 32'h1);
      irq_is(1'b1);
      rd(ADR_PC_LO, 32'h3c, "jump low");
      rd(ADR_PCH, 32'h05, "jump page");
      wr(ADR_IRQ, 8'h01);
      irq_is(1'b0);
      wr(ADR_MASK, 8'h00);
      wr(ADR_PC_LO, 8'h3d);
      irq_is(1'b0);
      rd(ADR_IRQ, 32'h01, "masked event");
   endtask
   task automatic t_table;
      wr(ADR_PTR_LO, 8'h34);
      wr(ADR_PTR_HI, 8'h12);
      bus(1'b1, ADR_TDAT, 32'ha55a, 4'hf);
      wr(ADR_CMD, {4'h0, OP_TABRD});
      rd(ADR_TBL_HI, 32'ha5, "table high");
      rd(ADR_TLOW, 32'h5a, "table low");
      rd(ADR_PTR_LO, 32'h34, "pointer low");
      rd(ADR_PTR_HI, 32'h12, "pointer high");
      wr(ADR_TBL_HI, 8'h77);
      rd(ADR_TBL_HI, 32'ha5, "table high kept");
      rd(ADR_IRQ, 32'h03, "events");
      wr(ADR_ACCUM, 8'h22);
      bus(1'b1, ADR_ACCUM, 32'h11, 4'he);
      rd(ADR_ACCUM, 32'h22, "byte lane off");
      rd(8'h38, 32'h0, "unmapped");
   endtask
   initial begin
      sys_rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'hf;
      adr = 8'h0;
      di = 32'h0;
      fails = 0;
      num_checks = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_flags;
      t_arith;
      t_logic;
      t_move;
      t_jump;
      t_table;
      report_and_stop;
   end
   initial begin
      #200000;
      fails++;
      report_and_stop;
   end
endmodule
`default_nettype wire
